// ===== src/dts_top.sv
// top: source selection, key memory ownership, hot plug gating and pattern generator
`timescale 1ns/1ns
module dts_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// video sources
	input dts_pkg::dts_video_t video_output_processor_a,
	input dts_pkg::dts_video_t video_output_processor_b,
	// audio sources
	input dts_pkg::dts_i2s_t eight_channel_i2s_source,
	input wire logic eight_channel_spdif_source,
	input wire logic two_channel_spdif_source,
	// shared hot plug pin
	input wire logic shared_hot_plug_pin,
	// toward the transmitter
	output dts_pkg::dts_video_t tx_video,
	output dts_pkg::dts_i2s_t tx_i2s,
	output logic tx_spdif,
	output logic tx_hot_plug,
	// transmitter side of the key memory
	input dts_pkg::dts_key_req_t tx_key_req,
	output logic [dts_pkg::KEY_DW-1:0] tx_key_rdata
);

	// ==========================================================
	// configuration registers
	logic [31:0] key_memory_owner_config_reg;
	logic [31:0] video_source_config_reg;
	logic [31:0] spdif_source_config_reg;
	logic [31:0] hot_plug_pin_function_reg;
	logic [31:0] pattern_ctrl_reg;
	logic [31:0] pattern_active_reg;
	logic [31:0] pattern_total_reg;

	logic key_owner_tx;
	logic video_sel_b;
	logic spdif_sel_two;
	logic [1:0] hot_plug_pin_function_field;
	logic pat_on;
	logic [1:0] pat_kind;
	logic [7:0] pat_div;
	logic [11:0] h_active;
	logic [11:0] v_active;
	logic [11:0] h_total;
	logic [11:0] v_total;

	assign key_owner_tx = key_memory_owner_config_reg[dts_pkg::KEY_OWNER_BIT];
	assign video_sel_b = video_source_config_reg[dts_pkg::VIDEO_SEL_BIT];
	assign spdif_sel_two = spdif_source_config_reg[dts_pkg::SPDIF_SEL_BIT];
	assign hot_plug_pin_function_field =
		hot_plug_pin_function_reg[dts_pkg::HPD_FUNC_MSB:dts_pkg::HPD_FUNC_LSB];
	assign pat_on = pattern_ctrl_reg[dts_pkg::PAT_EN_BIT];
	assign pat_kind = pattern_ctrl_reg[dts_pkg::PAT_TYPE_LSB +: 2];
	assign pat_div = pattern_ctrl_reg[dts_pkg::PAT_DIV_LSB +: 8];
	assign h_active = pattern_active_reg[11:0];
	assign v_active = pattern_active_reg[27:16];
	assign h_total = pattern_total_reg[11:0];
	assign v_total = pattern_total_reg[27:16];

	// ==========================================================
	// apb decode
	logic setup;
	logic access_done;
	logic in_window;
	logic mem_hit;
	logic mem_denied;
	logic reg_hit;
	logic wr_done;

	assign setup = psel && !penable;
	assign access_done = psel && penable && pready;
	assign in_window = paddr[11] && (paddr[1:0] == 2'h0);
	assign mem_hit = in_window && !key_owner_tx;
	assign mem_denied = in_window && key_owner_tx;
	assign wr_done = access_done && pwrite;

	always_comb begin
		reg_hit = 1'b0;
		unique case (paddr)
			dts_pkg::OFS_KEY_MEMORY_OWNER_CONFIG_REG,
			dts_pkg::OFS_VIDEO_SOURCE_CONFIG_REG,
			dts_pkg::OFS_SPDIF_SOURCE_CONFIG_REG,
			dts_pkg::OFS_HOT_PLUG_PIN_FUNCTION_REG,
			dts_pkg::OFS_PATTERN_CTRL_REG,
			dts_pkg::OFS_PATTERN_ACTIVE_REG,
			dts_pkg::OFS_PATTERN_TOTAL_REG,
			dts_pkg::OFS_STATUS_REG: begin
				reg_hit = 1'b1;
			end
			default: begin
				reg_hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// key memory ownership
	dts_pkg::dts_key_req_t bus_key_req;
	dts_pkg::dts_key_req_t mem_req;
	logic [dts_pkg::KEY_DW-1:0] mem_rdata;

	// bus reads are issued in the setup cycle, writes land at the completing edge
	always_comb begin
		bus_key_req.en = mem_hit && ((setup && !pwrite) || wr_done);
		bus_key_req.we = pwrite;
		bus_key_req.addr = paddr[dts_pkg::KEY_AW+1:2];
		bus_key_req.wdata = pwdata[dts_pkg::KEY_DW-1:0];
	end

	// the switch is not glitch-guarded; software flips it only while idle
	assign mem_req = key_owner_tx ? tx_key_req : bus_key_req;

	dts_key_mem u_key_mem (
		.pclk(pclk),
		.req(mem_req),
		.rdata(mem_rdata)
	);

	assign tx_key_rdata = mem_rdata;

	// ==========================================================
	// apb answer: registers without wait, key memory with one wait cycle
	logic [31:0] status_word;
	logic [31:0] next_rdata;
	logic hot_plug_level;
	logic [15:0] frame_count;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[dts_pkg::STAT_HPD_BIT] = hot_plug_level;
		status_word[dts_pkg::STAT_OWNER_BIT] = key_owner_tx;
		status_word[dts_pkg::STAT_PAT_BIT] = pat_on;
		status_word[dts_pkg::STAT_FRAME_LSB +: 16] = frame_count;
	end

	always_comb begin
		unique case (paddr)
			dts_pkg::OFS_KEY_MEMORY_OWNER_CONFIG_REG: next_rdata = key_memory_owner_config_reg;
			dts_pkg::OFS_VIDEO_SOURCE_CONFIG_REG: next_rdata = video_source_config_reg;
			dts_pkg::OFS_SPDIF_SOURCE_CONFIG_REG: next_rdata = spdif_source_config_reg;
			dts_pkg::OFS_HOT_PLUG_PIN_FUNCTION_REG: next_rdata = hot_plug_pin_function_reg;
			dts_pkg::OFS_PATTERN_CTRL_REG: next_rdata = pattern_ctrl_reg;
			dts_pkg::OFS_PATTERN_ACTIVE_REG: next_rdata = pattern_active_reg;
			dts_pkg::OFS_PATTERN_TOTAL_REG: next_rdata = pattern_total_reg;
			dts_pkg::OFS_STATUS_REG: next_rdata = status_word;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !pready && (penable ? mem_hit : !mem_hit);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup && !mem_hit) begin
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= mem_denied || !reg_hit;
		end else if (psel && penable && !pready && mem_hit) begin
			prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, mem_rdata};
			pslverr <= 1'b0;
		end
	end

	// ==========================================================
	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_memory_owner_config_reg <= dts_pkg::RST_CONFIG;
			video_source_config_reg <= dts_pkg::RST_CONFIG;
			spdif_source_config_reg <= dts_pkg::RST_CONFIG;
			hot_plug_pin_function_reg <= dts_pkg::RST_CONFIG;
			pattern_ctrl_reg <= dts_pkg::RST_CONFIG;
			pattern_active_reg <= {4'h0, dts_pkg::RST_V_ACTIVE, 4'h0, dts_pkg::RST_H_ACTIVE};
			pattern_total_reg <= {4'h0, dts_pkg::RST_V_TOTAL, 4'h0, dts_pkg::RST_H_TOTAL};
		end else if (wr_done) begin
			unique case (paddr)
				dts_pkg::OFS_KEY_MEMORY_OWNER_CONFIG_REG: begin
					key_memory_owner_config_reg <= pwdata;
				end
				dts_pkg::OFS_VIDEO_SOURCE_CONFIG_REG: begin
					video_source_config_reg <= pwdata;
				end
				dts_pkg::OFS_SPDIF_SOURCE_CONFIG_REG: begin
					spdif_source_config_reg <= pwdata;
				end
				dts_pkg::OFS_HOT_PLUG_PIN_FUNCTION_REG: begin
					hot_plug_pin_function_reg <= pwdata;
				end
				dts_pkg::OFS_PATTERN_CTRL_REG: begin
					pattern_ctrl_reg <= pwdata;
				end
				dts_pkg::OFS_PATTERN_ACTIVE_REG: begin
					pattern_active_reg <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
				end
				dts_pkg::OFS_PATTERN_TOTAL_REG: begin
					pattern_total_reg <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// hot plug pin synchroniser and gate
	logic [2:0] hpd_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hpd_sync <= 3'h0;
		end else begin
			hpd_sync <= {hpd_sync[1:0], shared_hot_plug_pin};
		end
	end

	// a level change counts only once the last two stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hot_plug_level <= 1'b0;
		end else if (hpd_sync[1] == hpd_sync[2]) begin
			hot_plug_level <= hpd_sync[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_hot_plug <= 1'b0;
		end else begin
			tx_hot_plug <= (hot_plug_pin_function_field == dts_pkg::HPD_FUNC_ENABLE) &&
				hot_plug_level;
		end
	end

	// ==========================================================
	// audio routing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_i2s <= '0;
			tx_spdif <= 1'b0;
		end else begin
			tx_i2s <= eight_channel_i2s_source;
			tx_spdif <= spdif_sel_two ? two_channel_spdif_source :
				eight_channel_spdif_source;
		end
	end

	// ==========================================================
	// pattern generator: pixel rate from a divider enable
	logic [7:0] div_cnt;
	logic pix_tick;
	logic [11:0] h_cnt;
	logic [11:0] v_cnt;
	dts_pkg::dts_video_t pat_video;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'h00;
			pix_tick <= 1'b0;
		end else begin
			pix_tick <= pat_on && (div_cnt == pat_div);
			div_cnt <= (!pat_on || div_cnt == pat_div) ? 8'h00 : div_cnt + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h_cnt <= 12'h000;
			v_cnt <= 12'h000;
			frame_count <= 16'h0000;
		end else if (!pat_on) begin
			h_cnt <= 12'h000;
			v_cnt <= 12'h000;
		end else if (pix_tick) begin
			if (h_cnt >= h_total - 12'h001) begin
				h_cnt <= 12'h000;
				if (v_cnt >= v_total - 12'h001) begin
					v_cnt <= 12'h000;
					frame_count <= frame_count + 16'h0001;
				end else begin
					v_cnt <= v_cnt + 12'h001;
				end
			end else begin
				h_cnt <= h_cnt + 12'h001;
			end
		end
	end

	// bars cycle through eight colour bands of 128 pixels each, taken from h_cnt bits 9 to 7
	always_comb begin
		pat_video.pix_en = pix_tick;
		pat_video.de = (h_cnt < h_active) && (v_cnt < v_active);
		pat_video.hs = (h_cnt >= h_active) && (h_cnt < h_active + dts_pkg::HSYNC_CYCLES);
		pat_video.vs = (v_cnt >= v_active) && (v_cnt < v_active + dts_pkg::VSYNC_LINES);
		unique case (dts_pkg::dts_pat_t'(pat_kind))
			dts_pkg::DTS_PAT_BARS: begin
				pat_video.data = {{8{h_cnt[9]}}, {8{h_cnt[8]}}, {8{h_cnt[7]}}};
			end
			dts_pkg::DTS_PAT_RAMP: begin
				pat_video.data = {3{h_cnt[7:0]}};
			end
			dts_pkg::DTS_PAT_FLAT: begin
				pat_video.data = pattern_ctrl_reg[31:8];
			end
			default: begin
				pat_video.data = 24'h00_0000;
			end
		endcase
		if (!pat_video.de) begin
			pat_video.data = 24'h00_0000;
		end
	end

	// ==========================================================
	// video routing into the capturer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_video <= '0;
		end else if (pat_on) begin
			tx_video <= pat_video;
		end else begin
			tx_video <= video_sel_b ? video_output_processor_b :
				video_output_processor_a;
		end
	end

endmodule // dts_top

// ===== src/dts_pkg.sv
// package: constants and carriers for the display transmitter source select block
package dts_pkg;

	// ==========================================================
	// register offsets (byte addresses on the apb bus)
	localparam logic [11:0] OFS_KEY_MEMORY_OWNER_CONFIG_REG = 12'h000;
	localparam logic [11:0] OFS_VIDEO_SOURCE_CONFIG_REG = 12'h004;
	localparam logic [11:0] OFS_SPDIF_SOURCE_CONFIG_REG = 12'h008;
	localparam logic [11:0] OFS_HOT_PLUG_PIN_FUNCTION_REG = 12'h00C;
	localparam logic [11:0] OFS_PATTERN_CTRL_REG = 12'h010;
	localparam logic [11:0] OFS_PATTERN_ACTIVE_REG = 12'h014;
	localparam logic [11:0] OFS_PATTERN_TOTAL_REG = 12'h018;
	localparam logic [11:0] OFS_STATUS_REG = 12'h01C;
	// key memory window: one byte per aligned word, 512 words
	localparam logic [11:0] OFS_KEY_WINDOW = 12'h800;

	// ==========================================================
	// field positions
	localparam int KEY_OWNER_BIT = 13;
	localparam int VIDEO_SEL_BIT = 5;
	localparam int SPDIF_SEL_BIT = 1;
	localparam int HPD_FUNC_LSB = 6;
	localparam int HPD_FUNC_MSB = 7;
	localparam logic [1:0] HPD_FUNC_ENABLE = 2'h2;
	localparam int PAT_EN_BIT = 0;
	localparam int PAT_TYPE_LSB = 4;
	localparam int PAT_DIV_LSB = 8;
	localparam int STAT_HPD_BIT = 0;
	localparam int STAT_OWNER_BIT = 1;
	localparam int STAT_PAT_BIT = 2;
	localparam int STAT_FRAME_LSB = 16;

	// ==========================================================
	// values after reset
	localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
	localparam logic [11:0] RST_H_ACTIVE = 12'h280;
	localparam logic [11:0] RST_V_ACTIVE = 12'h1E0;
	localparam logic [11:0] RST_H_TOTAL = 12'h320;
	localparam logic [11:0] RST_V_TOTAL = 12'h20D;

	// ==========================================================
	// sizes and cycle counts
	localparam int KEY_WORDS = 512;
	localparam int KEY_AW = 9;
	localparam int KEY_DW = 8;
	localparam int PIX_DW = 24;
	localparam logic [11:0] HSYNC_CYCLES = 12'h060;
	localparam logic [11:0] VSYNC_LINES = 12'h002;

	// three kinds of fill for the pattern generator
	typedef enum logic [1:0] {
		DTS_PAT_BARS = 2'h0,
		DTS_PAT_RAMP = 2'h1,
		DTS_PAT_FLAT = 2'h3
	} dts_pat_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic pix_en;
		logic de;
		logic hs;
		logic vs;
		logic [PIX_DW-1:0] data;
	} dts_video_t;

	typedef struct packed {
		logic sck;
		logic ws;
		logic [3:0] sd;
	} dts_i2s_t;

	typedef struct packed {
		logic en;
		logic we;
		logic [KEY_AW-1:0] addr;
		logic [KEY_DW-1:0] wdata;
	} dts_key_req_t;

endpackage

// ===== src/dts_key_mem.sv
// single-port key storage memory with registered read data
`timescale 1ns/1ns
module dts_key_mem (
	// clock
	input wire logic pclk,
	// access port
	input dts_pkg::dts_key_req_t req,
	output logic [dts_pkg::KEY_DW-1:0] rdata
);

	// ==========================================================
	// storage
	logic [dts_pkg::KEY_DW-1:0] mem [dts_pkg::KEY_WORDS];

	always_ff @(posedge pclk) begin
		if (req.en && req.we) begin
			mem[req.addr] <= req.wdata;
		end
	end

	// no reset on the read register: memory contents are undefined anyway
	always_ff @(posedge pclk) begin
		if (req.en && !req.we) begin
			rdata <= mem[req.addr];
		end
	end

endmodule // dts_key_mem

// ===== tb/dts_checker.sv
// checker: port-level properties of the source select block
`timescale 1ns/1ns
module dts_checker (
	// clock, reset and apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// sources
	input dts_pkg::dts_video_t video_output_processor_a,
	input dts_pkg::dts_video_t video_output_processor_b,
	input dts_pkg::dts_i2s_t eight_channel_i2s_source,
	input wire logic eight_channel_spdif_source,
	input wire logic two_channel_spdif_source,
	// transmitter side
	input dts_pkg::dts_video_t tx_video,
	input dts_pkg::dts_i2s_t tx_i2s,
	input wire logic tx_spdif,
	input wire logic tx_hot_plug
);
	logic own, vsel, ssel;
	logic [1:0] hpf, up;
	logic [31:0] pctl;
	wire acc = psel & penable & pready;
	wire key = paddr[11];
	// =====================================================
	// mirror of the select fields, caught at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{own, vsel, ssel, hpf, pctl} <= '0;
		end else if (acc && pwrite) begin
			case (paddr)
				12'h000: own <= pwdata[13];
				12'h004: vsel <= pwdata[5];
				12'h008: ssel <= pwdata[1];
				12'h00C: hpf <= pwdata[7:6];
				12'h010: pctl <= pwdata;
				default: ;
			endcase
		end
	end
	// $past must not reach back into reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	// =====================================================
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_video_pick: assert property (up == 2'h3 && !$past(pctl[0]) |-> tx_video ==
		($past(vsel) ? $past(video_output_processor_b) :
		$past(video_output_processor_a))) else $error("video source pick wrong");
	a_spdif_pick: assert property (up == 2'h3 |-> tx_spdif ==
		($past(ssel) ? $past(two_channel_spdif_source) :
		$past(eight_channel_spdif_source))) else $error("spdif source pick wrong");
	a_i2s_pass: assert property (up == 2'h3 |-> tx_i2s == $past(eight_channel_i2s_source))
		else $error("i2s not passed through");
	a_hpd_block: assert property (up == 2'h3 && hpf != 2'h2 && $past(hpf) != 2'h2
		|-> !tx_hot_plug) else $error("hot plug leaks through");
	a_key_deny: assert property (acc && key && own |-> pslverr)
		else $error("bus key access not refused");
	a_key_grant: assert property (acc && key && !own && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("bus key access refused");
	a_key_wait: assert property (psel && !penable && key && !own && paddr[1:0] == 2'h0
		|=> !pready ##1 pready) else $error("key access timing wrong");
	a_pat_flat: assert property (up == 2'h3 && pctl[0] && pctl[5:4] == 2'h3 &&
		$past(pctl, 4) == pctl && tx_video.de |-> tx_video.data == pctl[31:8])
		else $error("flat pattern colour wrong");
	c_key_deny: cover property (acc && key && own);
	c_pat_de: cover property (pctl[0] && tx_video.de);
	c_hpd_on: cover property (tx_hot_plug);
endmodule // dts_checker

bind dts_top dts_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr),
	.video_output_processor_a(video_output_processor_a),
	.video_output_processor_b(video_output_processor_b),
	.eight_channel_i2s_source(eight_channel_i2s_source),
	.eight_channel_spdif_source(eight_channel_spdif_source),
	.two_channel_spdif_source(two_channel_spdif_source), .tx_video(tx_video),
	.tx_i2s(tx_i2s), .tx_spdif(tx_spdif), .tx_hot_plug(tx_hot_plug));

// ===== tb/dts_source_model.sv
// model of the video and audio sources feeding the transmitter
`timescale 1ns/1ns
module dts_source_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sources
	output dts_pkg::dts_video_t vid_a,
	output dts_pkg::dts_video_t vid_b,
	output dts_pkg::dts_i2s_t i2s,
	output logic spdif8,
	output logic spdif2
);
	logic [23:0] cnt;
	// odd step: every stream but spdif2 moves each cycle; spdif8 and spdif2 differ on half of the cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt <= 24'h000001;
		else cnt <= cnt + 24'h0F3A57;
	end
	assign vid_a = {cnt[3:0], cnt};
	assign vid_b = {~cnt[3:0], cnt ^ 24'hA5C3F0};
	assign i2s = cnt[5:0];
	assign spdif8 = cnt[0];
	assign spdif2 = cnt[1];
endmodule // dts_source_model

// ===== tb/display_tx_source_select_test.sv
// testbench for the display transmitter source select block
`timescale 1ns/1ns
module display_tx_source_select_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hp_pin = 0, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, s8, s2, txs, txh, s8_d, s2_d;
	dts_pkg::dts_video_t va, vb, txv, va_d, vb_d;
	dts_pkg::dts_i2s_t i2s, txi, i2s_d;
	dts_pkg::dts_key_req_t kreq = '0;
	logic [7:0] krd;
	int mismatches = 0, n_checks = 0;

	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		va_d <= va;
		vb_d <= vb;
		i2s_d <= i2s;
		s8_d <= s8;
		s2_d <= s2;
	end

	dts_source_model u_src (.pclk(pclk), .presetn(presetn), .vid_a(va), .vid_b(vb),
		.i2s(i2s), .spdif8(s8), .spdif2(s2));
	dts_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .video_output_processor_a(va),
		.video_output_processor_b(vb), .eight_channel_i2s_source(i2s),
		.eight_channel_spdif_source(s8), .two_channel_spdif_source(s2),
		.shared_hot_plug_pin(hp_pin), .tx_video(txv), .tx_i2s(txi), .tx_spdif(txs),
		.tx_hot_plug(txh), .tx_key_req(kreq), .tx_key_rdata(krd));

	// =====================================================
	// shared tasks
	task automatic check(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// entered just after a rising edge, leaves just after one
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait limit here: a hung transfer is ended by the watchdog
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic xe);
		apb(1'b0, a, 32'h0);
		check("read data", rd, exp);
		check("read error", {31'h0, er}, {31'h0, xe});
	endtask
	task automatic key_tx(input logic we, input logic [8:0] a, input logic [7:0] d);
		kreq <= '{en: 1'b1, we: we, addr: a, wdata: d};
		@(posedge pclk);
		kreq.en <= 1'b0;
		@(posedge pclk);
	endtask

	// =====================================================
	// scenarios
	task automatic t_reset;
		rdchk(12'h000, 32'h0, 1'b0);
		rdchk(12'h014, 32'h01E0_0280, 1'b0);
		rdchk(12'h018, 32'h020D_0320, 1'b0);
		rdchk(12'h020, 32'h0, 1'b1);
	endtask
	// the other bits are set the opposite way to show only the select bit counts
	task automatic t_sources;
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, 12'h004, s ? 32'h0000_0020 : 32'hFFFF_FFDF);
			apb(1'b1, 12'h008, s ? 32'h0000_0002 : 32'hFFFF_FFFD);
			repeat (4) begin
				@(negedge pclk);
				check("video", {4'h0, txv}, {4'h0, s ? vb_d : va_d});
				check("spdif", {31'h0, txs}, {31'h0, s ? s2_d : s8_d});
				check("i2s", {26'h0, txi}, {26'h0, i2s_d});
			end
			@(posedge pclk);
		end
	endtask
	task automatic t_hot_plug;
		hp_pin <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, 12'h00C, 32'(f) << 6);
			repeat (8) @(posedge pclk);
			check("hot plug", {31'h0, txh}, {31'h0, f == 2});
		end
		apb(1'b1, 12'h00C, 32'h0000_0080);
		hp_pin <= 1'b0;
		repeat (8) @(posedge pclk);
		check("hot plug low", {31'h0, txh}, 32'h0);
	endtask
	task automatic t_key;
		apb(1'b1, 12'h800, 32'hFFFF_FF5A);
		apb(1'b1, 12'hFFC, 32'h0000_00C3);
		rdchk(12'hFFC, 32'h0000_00C3, 1'b0);
		key_tx(1'b1, 9'h000, 8'h11);
		rdchk(12'h800, 32'h0000_005A, 1'b0);
		// both sides idle here, so the owner may flip
		apb(1'b1, 12'h000, 32'h0000_2000);
		rdchk(12'h800, 32'h0, 1'b1);
		apb(1'b1, 12'h800, 32'h0000_0099);
		check("denied write", {31'h0, er}, 32'h1);
		key_tx(1'b0, 9'h1FF, 8'h00);
		check("tx read", {24'h0, krd}, 32'h0000_00C3);
		key_tx(1'b1, 9'h000, 8'h66);
		key_tx(1'b0, 9'h000, 8'h00);
		check("tx write", {24'h0, krd}, 32'h0000_0066);
		apb(1'b1, 12'h000, 32'h0);
		rdchk(12'h800, 32'h0000_0066, 1'b0);
	endtask
	// small frame keeps the wait for active video short
	task automatic t_pattern;
		int n;
		apb(1'b1, 12'h014, 32'h0004_0010);
		apb(1'b1, 12'h018, 32'h0008_0080);
		for (int t = 0; t < 4; t++) begin
			if (t == 2) continue;
			apb(1'b1, 12'h010, 32'hABCD_0001 | (32'(t) << 4));
			// one more edge so the output no longer shows the old setting
			@(posedge pclk);
			n = 0;
			while (txv.de !== 1'b1 && n < 3000) begin
				n++;
				@(posedge pclk);
			end
			check("pattern de", {31'h0, txv.de}, 32'h1);
			if (t == 3) check("flat", {8'h0, txv.data}, 32'h00AB_CD00);
		end
		// hot plug low, bus owner, pattern on, no frame finished yet
		rdchk(12'h01C, 32'h0000_0004, 1'b0);
		check("pattern on", {31'h0, rd[2]}, 32'h1);
		apb(1'b1, 12'h010, 32'h0);
		@(negedge pclk);
		// video select was left on processor b by the source scenario
		check("video back", {4'h0, txv}, {4'h0, vb_d});
		@(posedge pclk);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_sources();
		t_hot_plug();
		t_key();
		t_pattern();
		finish_test();
	end
	initial begin
		#40000;
		mismatches++;
		finish_test();
	end
endmodule // display_tx_source_select_test
